// >>> core/swsr_line_avg.sv
// signed average of pixel samples over a power-of-two number of lines
module swsr_line_avg #(
	parameter int DW = 12,
	parameter int SPL_LOG2 = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic samp_vld_i,
	input wire logic signed [DW-1:0] samp_i,
	input wire logic line_end_i,
	input wire logic [1:0] lines_log2_i,
	input wire logic [3:0] spl_log2_i,
	output logic signed [DW-1:0] avg_o,
	output logic busy_o
);
	import swsr_pkg::*;

	localparam int SW = DW + SPL_LOG2 + 3;

	if (DW < 2 || SPL_LOG2 < 1 || SPL_LOG2 > 14) begin : g_chk
		$error("swsr_line_avg: unsupported width or sample count");
	end

	typedef enum logic {AVG_IDLE = 1'b0, AVG_ACC = 1'b1} swsr_avg_st_t;

	swsr_avg_st_t state;
	logic signed [SW-1:0] sum;
	logic [SPL_LOG2:0] scnt;
	logic [3:0] lcnt;

	// a sample count above SPL_LOG2 wraps the limit to zero and no sample is taken
	wire [SPL_LOG2:0] spl_lim = {{SPL_LOG2{1'b0}}, 1'b1} << spl_log2_i;
	wire [3:0] lines_lim = 4'h1 << lines_log2_i;
	wire take = state == AVG_ACC && samp_vld_i && scnt < spl_lim;
	wire signed [SW-1:0] next_sum = sum + (take ? SW'(samp_i) : SW'(0));
	wire last = state == AVG_ACC && line_end_i && (lcnt + 4'h1) == lines_lim;
	wire [4:0] shift = {3'b000, lines_log2_i} + {1'b0, spl_log2_i};
	wire signed [SW-1:0] quot = next_sum >>> shift;

	assign busy_o = state == AVG_ACC;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= AVG_IDLE;
			sum <= '0;
			scnt <= '0;
			lcnt <= '0;
			avg_o <= '0;
		end else if (srst_i) begin
			// soft reset is synchronous so it stays out of the asynchronous reset path
			state <= AVG_IDLE;
			sum <= '0;
			scnt <= '0;
			lcnt <= '0;
			avg_o <= '0;
		end else begin
			case (state)
				AVG_IDLE: begin
					if (start_i) begin
						sum <= '0;
						scnt <= '0;
						lcnt <= '0;
						state <= AVG_ACC;
					end
				end
				AVG_ACC: begin
					sum <= next_sum;
					scnt <= line_end_i ? '0 : scnt + (SPL_LOG2+1)'(take);
					lcnt <= line_end_i ? lcnt + 4'h1 : lcnt;
					if (last) begin
						avg_o <= quot[DW-1:0]; // RULE_03 RULE_04
						state <= AVG_IDLE;
					end
				end
				default: state <= AVG_IDLE;
			endcase
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	avg_hold_a: assert property (!last && !srst_i |=> $stable(avg_o)) // RULE_03
		else $error("average changed outside the last line");
	avg_clear_a: assert property (srst_i |=> avg_o == '0 && !busy_o) // RULE_04
		else $error("average not cleared by soft reset");
	samp_cap_a: assert property (busy_o && !srst_i && !line_end_i && scnt == spl_lim // RULE_03
		|=> scnt == $past(scnt))
		else $error("sample count ran past its limit");
	avg_done_c: cover property (last);
endmodule

// >>> core/swsr_pkg.sv
// shared constants and types for the window, status and setup register bank
package swsr_pkg;
	localparam logic [6:0] OFF_XEND_H = 7'h05;
	localparam logic [6:0] OFF_XEND_L = 7'h06;
	localparam logic [6:0] OFF_YEND_H = 7'h07;
	localparam logic [6:0] OFF_YEND_L = 7'h08;
	localparam logic [6:0] OFF_DARK_H = 7'h09;
	localparam logic [6:0] OFF_DARK_L = 7'h0a;
	localparam logic [6:0] OFF_BLACK_H = 7'h0b;
	localparam logic [6:0] OFF_BLACK_L = 7'h0c;
	localparam logic [6:0] OFF_CLIP = 7'h0d;
	localparam logic [6:0] OFF_SETUP = 7'h10;

	localparam logic [8:0] XEND_RST = 9'h167;
	localparam logic [8:0] YEND_RST = 9'h125;
	localparam logic [7:0] SETUP_RST = 8'h09;
	localparam logic [7:0] SETUP_RD_MASK = 8'hcb;

	localparam int SET_LP = 0;
	localparam int SET_SLP = 1;
	localparam int SET_SRST = 2;
	localparam int SET_RATE = 3;
	localparam int CLIP_X = 0;
	localparam int CLIP_Y = 1;

	localparam logic [3:0] DIV_CIF = 4'h4;
	localparam logic [3:0] DIV_TV = 4'h2;
	localparam logic [3:0] DIV_QCIF = 4'h8;
	localparam logic [8:0] W_FULL = 9'h164;
	localparam logic [8:0] H_FULL = 9'h124;
	localparam logic [8:0] W_NTSC = 9'h132;
	localparam logic [8:0] H_NTSC = 9'h0f4;
	localparam logic [8:0] W_QCIF = 9'h0b4;
	localparam logic [8:0] H_QCIF = 9'h094;
	localparam logic [8:0] LL_CIF25 = 9'h1f4;
	localparam logic [8:0] LL_CIF30 = 9'h1a0;
	localparam logic [8:0] LL_PAL = 9'h1c6;
	localparam logic [8:0] LL_NTSC = 9'h16c;
	localparam logic [8:0] LL_Q25 = 9'h0fa;
	localparam logic [8:0] LL_Q30 = 9'h0d0;
	localparam logic [8:0] FL_CIF = 9'h140;
	localparam logic [8:0] FL_PAL = 9'h138;
	localparam logic [8:0] FL_NTSC = 9'h106;
	localparam logic [8:0] FL_QCIF = 9'h0a0;

	localparam int SUB_GRP_LOG2 = 2;
	localparam logic [3:0] SPL_LOG2_FULL = 4'h8;
	localparam logic [3:0] SPL_LOG2_QCIF = 4'h7;
	localparam logic [3:0] DATA_IDLE = 4'hf;

	typedef enum logic [1:0] {
		SWSR_CIF = 2'b00,
		SWSR_TV = 2'b01,
		SWSR_PAN = 2'b10,
		SWSR_SUB = 2'b11
	} swsr_mode_t;

	typedef struct packed {
		logic [3:0] div;
		logic [8:0] width;
		logic [8:0] height;
		logic [8:0] line_len;
		logic [8:0] field_len;
		logic field_alt;
	} swsr_timing_t;

	typedef struct packed {
		logic [8:0] x;
		logic [8:0] y;
	} swsr_xy_t;

	typedef struct packed {
		swsr_xy_t start;
		swsr_xy_t stop;
	} swsr_win_t;
endpackage

// >>> core/swsr_regs.sv
// window end, calibration average, clip status and main setup register bank
// Summary of operation
// RULE_01 - window end column, 9 bits, default 359
// RULE_02 - window end row, 9 bits, default 293
// RULE_03 - dark average over 1/2/4 lines, signed 12
// RULE_04 - black average over 4/8 lines, reset zero
// RULE_05 - clip bit 0 when x offset clips
// RULE_06 - clip bit 1 for y; upper bits zero
// RULE_07 - low power: array down, bus F, set
// RULE_08 - sleep: array in reset, bus F
// RULE_09 - soft reset bit restores defaults, self-clears
// RULE_10 - bit 3 picks 25 or 30 fps
// RULE_11 - bits 7:6 select the timing mode
// RULE_12 - pan/tilt: QCIF window from offset registers
// RULE_13 - sub-sample: keep alternate groups of four
// RULE_14 - CIF: divide 4, 500/416 line, 320
// RULE_15 - PAL/NTSC: divide 2, TV line, fields
// RULE_16 - QCIF: divide 8, 250/208 line, 160
// RULE_17 - clip flags follow applied window values
module swsr_regs #(
	parameter int AVG_W = 12
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic frame_start_i,
	input wire swsr_pkg::swsr_xy_t win_off_i,
	output swsr_pkg::swsr_win_t win_o,
	output swsr_pkg::swsr_timing_t timing_o,
	output logic subsample_o,
	output logic array_pwr_dn_o,
	output logic array_rst_o,
	output logic soft_rst_o,
	input wire logic [3:0] vid_nib_i,
	output logic [3:0] data_o,
	input wire logic [8:0] pix_col_i,
	input wire logic [8:0] pix_row_i,
	output logic pix_keep_o,
	input wire logic dark_start_i,
	input wire logic black_start_i,
	input wire logic dark_line_i,
	input wire logic samp_vld_i,
	input wire logic signed [AVG_W-1:0] samp_i,
	input wire logic line_end_i,
	input wire logic [1:0] dark_lines_i,
	input wire logic black_lines_i
);
	import swsr_pkg::*;

	if (AVG_W != 12) begin : g_chk
		$error("swsr_regs: averages are read as a 4-bit and an 8-bit field");
	end

	function automatic swsr_timing_t timing_of(input swsr_mode_t m, input logic r30);
		swsr_timing_t t;
		t = '0;
		case (m)
			SWSR_CIF: begin
				t = '{DIV_CIF, W_FULL, H_FULL, r30 ? LL_CIF30 : LL_CIF25, FL_CIF, 1'b0}; // RULE_14
			end
			SWSR_TV: begin
				t.div = DIV_TV; // RULE_15
				t.width = r30 ? W_NTSC : W_FULL;
				t.height = r30 ? H_NTSC : H_FULL;
				t.line_len = r30 ? LL_NTSC : LL_PAL;
				t.field_len = r30 ? FL_NTSC : FL_PAL;
				t.field_alt = 1'b1;
			end
			default: begin
				t = '{DIV_QCIF, W_QCIF, H_QCIF, r30 ? LL_Q30 : LL_Q25, FL_QCIF, 1'b0}; // RULE_16
			end
		endcase
		return t;
	endfunction

	// returns {clipped, start, stop}; a window wider than the limit starts at zero
	function automatic logic [18:0] clip_of(input logic [8:0] off, input logic [8:0] size,
			input logic [8:0] lim);
		logic [9:0] need;
		logic [8:0] st;
		logic hit;
		need = {1'b0, off} + {1'b0, size} - 10'h001;
		hit = need > {1'b0, lim};
		st = !hit ? off : (lim >= size - 9'h001) ? lim - size + 9'h001 : 9'h000;
		return {hit, st, hit ? lim : need[8:0]};
	endfunction

	function automatic logic grp_kept(input logic [8:0] v);
		return !v[SUB_GRP_LOG2];
	endfunction

	logic [8:0] xend;
	logic [8:0] yend;
	logic [7:0] setup;
	logic [1:0] clip;
	logic srst;
	logic signed [AVG_W-1:0] dark_avg;
	logic signed [AVG_W-1:0] black_avg;

	wire wr_xh = reg_wr_i && reg_addr_i == OFF_XEND_H;
	wire wr_xl = reg_wr_i && reg_addr_i == OFF_XEND_L;
	wire wr_yh = reg_wr_i && reg_addr_i == OFF_YEND_H;
	wire wr_yl = reg_wr_i && reg_addr_i == OFF_YEND_L;
	wire wr_set = reg_wr_i && reg_addr_i == OFF_SETUP;
	wire next_srst = wr_set && reg_wdata_i[SET_SRST] && !srst;

	wire swsr_mode_t mode = swsr_mode_t'(setup[7:6]); // RULE_11
	wire rate30 = setup[SET_RATE]; // RULE_10
	wire swsr_timing_t next_timing = timing_of(mode, rate30);
	wire [18:0] cx = clip_of(win_off_i.x, next_timing.width, xend); // RULE_12
	wire [18:0] cy = clip_of(win_off_i.y, next_timing.height, yend);
	wire qcif = mode == SWSR_PAN || mode == SWSR_SUB;
	wire blank = setup[SET_LP] || setup[SET_SLP];
	wire next_keep = mode != SWSR_SUB || (grp_kept(pix_col_i) && grp_kept(pix_row_i));

	wire [7:0] rd_mux =
		reg_addr_i == OFF_XEND_H ? {7'h00, xend[8]} :
		reg_addr_i == OFF_XEND_L ? xend[7:0] :
		reg_addr_i == OFF_YEND_H ? {7'h00, yend[8]} :
		reg_addr_i == OFF_YEND_L ? yend[7:0] :
		reg_addr_i == OFF_DARK_H ? {4'h0, dark_avg[11:8]} :
		reg_addr_i == OFF_DARK_L ? dark_avg[7:0] :
		reg_addr_i == OFF_BLACK_H ? {4'h0, black_avg[11:8]} :
		reg_addr_i == OFF_BLACK_L ? black_avg[7:0] :
		reg_addr_i == OFF_CLIP ? {6'h00, clip} : // RULE_06
		reg_addr_i == OFF_SETUP ? (setup & SETUP_RD_MASK) : 8'h00;

	// soft reset takes one cycle so the write that asked for it is itself discarded
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			srst <= 1'b0;
		end else begin
			srst <= next_srst; // RULE_09
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			xend <= XEND_RST;
			yend <= YEND_RST;
			setup <= SETUP_RST;
		end else if (srst) begin
			xend <= XEND_RST; // RULE_01 RULE_09
			yend <= YEND_RST; // RULE_02
			setup <= SETUP_RST; // RULE_07 RULE_08 RULE_10
		end else begin
			xend[8] <= wr_xh ? reg_wdata_i[0] : xend[8]; // RULE_01
			xend[7:0] <= wr_xl ? reg_wdata_i : xend[7:0];
			yend[8] <= wr_yh ? reg_wdata_i[0] : yend[8]; // RULE_02
			yend[7:0] <= wr_yl ? reg_wdata_i : yend[7:0];
			setup <= wr_set ? (reg_wdata_i & SETUP_RD_MASK) : setup;
		end
	end

	// the window and its clip flags move together only at a frame boundary or a soft reset
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clip <= 2'b00;
			win_o <= '0;
		end else if (srst) begin
			clip <= 2'b00;
			win_o <= '0;
		end else if (frame_start_i) begin
			clip <= {cy[18], cx[18]}; // RULE_05 RULE_06 RULE_17
			win_o <= '{'{cx[17:9], cy[17:9]}, '{cx[8:0], cy[8:0]}};
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			timing_o <= '0;
			subsample_o <= 1'b0;
			data_o <= DATA_IDLE;
			pix_keep_o <= 1'b1;
			reg_rdata_o <= 8'h00;
		end else begin
			timing_o <= next_timing; // RULE_14 RULE_15 RULE_16
			subsample_o <= mode == SWSR_SUB;
			data_o <= blank ? DATA_IDLE : vid_nib_i; // RULE_07 RULE_08
			pix_keep_o <= next_keep; // RULE_13
			reg_rdata_o <= reg_rd_i ? rd_mux : reg_rdata_o;
		end
	end

	assign array_pwr_dn_o = setup[SET_LP]; // RULE_07
	assign array_rst_o = setup[SET_SLP]; // RULE_08
	assign soft_rst_o = srst;

	swsr_line_avg #(
		.DW(AVG_W),
		.SPL_LOG2(8)
	) u_dark (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.srst_i(srst),
		.start_i(dark_start_i),
		.samp_vld_i(samp_vld_i && dark_line_i),
		.samp_i(samp_i),
		.line_end_i(line_end_i && dark_line_i),
		.lines_log2_i(dark_lines_i == 2'b11 ? 2'b10 : dark_lines_i), // RULE_03
		.spl_log2_i(qcif ? SPL_LOG2_QCIF : SPL_LOG2_FULL),
		.avg_o(dark_avg),
		.busy_o()
	);

	swsr_line_avg #(
		.DW(AVG_W),
		.SPL_LOG2(8)
	) u_black (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.srst_i(srst),
		.start_i(black_start_i),
		.samp_vld_i(samp_vld_i && !dark_line_i),
		.samp_i(samp_i),
		.line_end_i(line_end_i && !dark_line_i),
		.lines_log2_i({1'b1, black_lines_i}), // RULE_04
		.spl_log2_i(qcif ? SPL_LOG2_QCIF : SPL_LOG2_FULL),
		.avg_o(black_avg),
		.busy_o()
	);

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	xend_write_a: assert property (wr_xl && !srst |=> xend[7:0] == $past(reg_wdata_i)) // RULE_01
		else $error("end column low byte not written");
	end_reset_a: assert property (srst |=> xend == XEND_RST ##0 yend == YEND_RST) // RULE_02
		else $error("window end not restored by soft reset");
	clip_x_a: assert property (frame_start_i && !srst && cx[18] |=> clip[CLIP_X]) // RULE_05
		else $error("x clip flag missing");
	clip_y_a: assert property (frame_start_i && !srst && cy[18] |=> clip[CLIP_Y]) // RULE_06
		else $error("y clip flag missing");
	clip_stop_a: assert property (frame_start_i && !srst && cx[18] // RULE_05
		|=> win_o.stop.x == $past(xend))
		else $error("clipped window does not stop at the end column");
	clip_read_a: assert property (reg_rd_i && reg_addr_i == OFF_CLIP // RULE_06
		|=> reg_rdata_o[7:2] == 6'h00)
		else $error("clip status upper bits not zero");
	clip_hold_a: assert property (!frame_start_i && !srst // RULE_17
		|=> $stable(clip) && $stable(win_o))
		else $error("clip flags moved between frames");
	// a setup write in the same cycle may legally leave low power
	power_bus_a: assert property (setup[SET_LP] && !wr_set // RULE_07
		|=> data_o == DATA_IDLE && array_pwr_dn_o)
		else $error("low power did not idle the bus");
	sleep_bus_a: assert property (setup[SET_SLP] |=> data_o == DATA_IDLE) // RULE_08
		else $error("sleep did not idle the bus");
	soft_rst_a: assert property (next_srst |=> srst ##1 (setup == SETUP_RST && !srst)) // RULE_09
		else $error("soft reset did not restore setup");
	setup_mask_a: assert property (wr_set && !srst // RULE_09
		|=> setup[SET_SRST] == 1'b0 && setup[5:4] == 2'b00)
		else $error("soft reset or reserved setup bit stored");
	cif_time_a: assert property (setup[7:6] == 2'b00 && !rate30 // RULE_14
		|=> timing_o.line_len == LL_CIF25 && timing_o.div == DIV_CIF)
		else $error("CIF 25 fps timing wrong");
	rate_sel_a: assert property (setup[7:6] == 2'b00 && rate30 // RULE_10
		|=> timing_o.line_len == LL_CIF30)
		else $error("30 fps rate not selected");
	pal_time_a: assert property (setup[7:6] == 2'b01 && !rate30 // RULE_15
		|=> timing_o.line_len == LL_PAL && timing_o.field_alt)
		else $error("PAL timing wrong");
	tv_time_a: assert property (setup[7:6] == 2'b01 && rate30 // RULE_15
		|=> timing_o.field_len == FL_NTSC && timing_o.div == DIV_TV)
		else $error("NTSC timing wrong");
	qcif_time_a: assert property (setup[7] && rate30 // RULE_16
		|=> timing_o.line_len == LL_Q30 && timing_o.width == W_QCIF)
		else $error("QCIF 30 fps timing wrong");
	pan_start_a: assert property (mode == SWSR_PAN && frame_start_i && !srst && !cx[18] // RULE_12
		|=> win_o.start.x == $past(win_off_i.x))
		else $error("pan window start not taken from offset");
	sub_skip_a: assert property (mode == SWSR_SUB && pix_col_i[SUB_GRP_LOG2] // RULE_13
		|=> !pix_keep_o)
		else $error("odd pixel group not skipped");
	sub_keep_a: assert property (mode != SWSR_SUB |=> pix_keep_o) // RULE_13
		else $error("pixel dropped outside sub-sampling");

	pan_frame_c: cover property (mode == SWSR_PAN && frame_start_i);
	soft_rst_c: cover property (next_srst);
	both_clip_c: cover property (frame_start_i && cx[18] && cy[18]);
	wake_c: cover property (setup[SET_LP] ##1 !setup[SET_LP]);
endmodule

// >>> tb/sensor_window_status_setup_regs_tb_top.sv
// self-checking bench for the window, status and setup register bank
module sensor_window_status_setup_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import swsr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr, rd, fs = 1'b0, ds = 1'b0, bs = 1'b0, dl = 1'b1, sv = 1'b0, le = 1'b0, bl = 1'b0;
	logic [6:0] addr;
	logic [7:0] wd, q;
	logic [3:0] nib = 4'h5;
	logic [3:0] dout;
	logic [8:0] col = 9'h000, row = 9'h000;
	logic [1:0] dln = 2'h1;
	logic signed [11:0] smp = 12'h000;
	swsr_xy_t off = '0;
	swsr_win_t win;
	swsr_timing_t tim;
	logic sub, pdn, ars, srst, keep;
	int fails = 0;
	int cmp_count = 0;
	swsr_timing_t te [0:7] = '{
		{4'h4, 9'h164, 9'h124, 9'h1f4, 9'h140, 1'b0}, {4'h4, 9'h164, 9'h124, 9'h1a0, 9'h140, 1'b0},
		{4'h2, 9'h164, 9'h124, 9'h1c6, 9'h138, 1'b1}, {4'h2, 9'h132, 9'h0f4, 9'h16c, 9'h106, 1'b1},
		{4'h8, 9'h0b4, 9'h094, 9'h0fa, 9'h0a0, 1'b0}, {4'h8, 9'h0b4, 9'h094, 9'h0d0, 9'h0a0, 1'b0},
		{4'h8, 9'h0b4, 9'h094, 9'h0fa, 9'h0a0, 1'b0}, {4'h8, 9'h0b4, 9'h094, 9'h0d0, 9'h0a0, 1'b0}};
	always #2 clk = ~clk;
	swsr_host_model i_host (.ref_clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wd), .reg_rdata_i(q));
	swsr_regs #(.AVG_W(12)) i_dut (.ref_clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(q), .frame_start_i(fs),
		.win_off_i(off), .win_o(win), .timing_o(tim), .subsample_o(sub),
		.array_pwr_dn_o(pdn), .array_rst_o(ars), .soft_rst_o(srst), .vid_nib_i(nib),
		.data_o(dout), .pix_col_i(col), .pix_row_i(row), .pix_keep_o(keep),
		.dark_start_i(ds), .black_start_i(bs), .dark_line_i(dl), .samp_vld_i(sv),
		.samp_i(smp), .line_end_i(le), .dark_lines_i(dln), .black_lines_i(bl));
	task automatic chk(input logic [40:0] got, input logic [40:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		if (fails == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wrr(input logic [6:0] a, input logic [7:0] d);
		i_host.xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] v;
		i_host.rd(a, v);
		chk(v, exp);
	endtask
	task automatic t_reset();
		logic [7:0] exp [0:11] = '{8'h01, 8'h67, 8'h01, 8'h25, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h09};
		for (int i = 0; i < 12; i++) begin
			rdc(7'h05 + 7'(i), exp[i]);
		end
		rdc(7'h7f, 8'h00);
		chk(tim, te[1]);
		chk({pdn, ars, dout}, {1'b1, 1'b0, 4'hf});
	endtask
	task automatic t_rw();
		wrr(7'h06, 8'h20);
		rdc(7'h06, 8'h20);
		wrr(7'h05, 8'hff);
		rdc(7'h05, 8'h01);
		wrr(7'h07, 8'hfe);
		rdc(7'h07, 8'h00);
		wrr(7'h08, 8'h11);
		rdc(7'h08, 8'h11);
		wrr(7'h0a, 8'h55);
		rdc(7'h0a, 8'h00);
		wrr(7'h0d, 8'hff);
		rdc(7'h0d, 8'h00);
	endtask
	task automatic t_srst();
		int n = 0;
		wrr(7'h10, 8'h04);
		while (srst !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		chk(n < 8, 1'b1);
		if (n == 8) end_sim();
		cyc(2);
		rdc(7'h06, 8'h67);
		rdc(7'h07, 8'h01);
		rdc(7'h10, 8'h09);
	endtask
	task automatic t_modes();
		logic [7:0] b;
		for (int i = 0; i < 8; i++) begin
			b = {2'(i >> 1), 2'b00, 1'(i), 3'b000};
			wrr(7'h10, b);
			cyc(2);
			rdc(7'h10, b);
			chk(tim, te[i]);
			chk({sub, dout}, {1'(i >= 6), nib});
		end
		col = 9'h004;
		cyc(2);
		chk(keep, 1'b0);
		col = 9'h008;
		cyc(2);
		chk(keep, 1'b1);
		wrr(7'h10, 8'h32);
		cyc(2);
		rdc(7'h10, 8'h02);
		chk({pdn, ars, dout}, {1'b0, 1'b1, 4'hf});
	endtask
	task automatic frame();
		fs = 1'b1;
		cyc(1);
		fs = 1'b0;
		cyc(1);
	endtask
	task automatic t_clip();
		wrr(7'h10, 8'h08);
		off = '{x: 9'h12c, y: 9'h000};
		frame();
		chk({win.start.x, win.stop.x}, {9'h004, 9'h167});
		rdc(7'h0d, 8'h01);
		off = '{x: 9'h000, y: 9'h064};
		frame();
		chk(win.start.y, 9'h002);
		rdc(7'h0d, 8'h02);
		wrr(7'h08, 8'hff);
		rdc(7'h0d, 8'h02);
		frame();
		rdc(7'h0d, 8'h00);
		chk(win.start.y, 9'h064);
	endtask
	task automatic line(input logic signed [11:0] v);
		sv = 1'b1;
		smp = v;
		cyc(256);
		sv = 1'b0;
		le = 1'b1;
		cyc(1);
		le = 1'b0;
	endtask
	task automatic t_avg();
		ds = 1'b1;
		cyc(1);
		ds = 1'b0;
		line(-12'sh003);
		line(12'sh005);
		cyc(2);
		rdc(7'h09, 8'h00);
		rdc(7'h0a, 8'h01);
		dl = 1'b0;
		bl = 1'b1;
		bs = 1'b1;
		cyc(1);
		bs = 1'b0;
		for (int i = 0; i < 8; i++) begin
			line((i % 2 == 0) ? -12'sh010 : 12'sh000);
		end
		cyc(2);
		rdc(7'h0b, 8'h0f);
		rdc(7'h0c, 8'hf8);
	endtask
	task automatic t_qcif_avg();
		wrr(7'h10, 8'h88);
		dl = 1'b1;
		dln = 2'h0;
		ds = 1'b1;
		cyc(1);
		ds = 1'b0;
		line(12'sh006);
		cyc(2);
		rdc(7'h09, 8'h00);
		rdc(7'h0a, 8'h06);
		dl = 1'b0;
		bl = 1'b0;
		bs = 1'b1;
		cyc(1);
		bs = 1'b0;
		repeat (4) line(12'sh007);
		cyc(2);
		rdc(7'h0b, 8'h00);
		rdc(7'h0c, 8'h07);
	endtask
	initial begin
		cyc(3);
		rst = 1'b0;
		t_reset();
		t_rw();
		t_srst();
		t_modes();
		t_clip();
		t_avg();
		t_qcif_avg();
		end_sim();
	end
	initial begin
		#400000;
		fails++;
		end_sim();
	end
endmodule

// >>> tb/swsr_host_model.sv
// register-port master standing in for the video coprocessor
module swsr_host_model (
	input wire logic ref_clk_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [6:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 7'h00;
		reg_wdata_o = 8'h00;
	end
	// released address and data flip so a stale value never looks valid
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		reg_wr_o = wr;
		reg_rd_o = !wr;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge ref_clk_i);
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask
	// read data stands from the edge after the strobe, so sample one cycle later
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		xfer(1'b0, a, 8'h00);
		@(negedge ref_clk_i);
		q = reg_rdata_i;
	endtask
endmodule
